// ### core/trap_flag_bit.sv
`timescale 1ns/10ps
`default_nettype none
// One sticky bit: hardware set beats software write
module trap_flag_bit (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic trap_set,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output logic      flag_q
);
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (wr_en) begin
      flag_d = wr_val;
    end
    if (trap_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule
`default_nettype wire

// ### core/trap_status_flags.sv
// Behaviour
// RL1 - An address error trap sets the address-error flag at bit 3, which is zero until one is recorded.
// RL2 - A stack error trap sets the stack-error flag at bit 2, which is zero until one is recorded.
// RL3 - An oscillator failure trap sets the clock-failure flag at bit 1, zero until one is recorded.
// RL4 - A math error trap sets the arithmetic-error flag at bit 4, which stays zero otherwise.
// RL5 - A math trap caused by division by zero sets the divide-zero cause flag at bit 6, else it stays zero.
// RL6 - All flags and the nesting-disable bit are writable, reset to zero, and unused bits read zero.
// RL7 - While the nesting-disable bit is one the three-bit CPU priority level cannot be written.
// RL8 - Bit 15 is the nesting-disable bit, held with the trap flags in one register.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module trap_status_flags (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire trap_pkg::trap_event_s        trap_ev,
  input  wire trap_pkg::reg_req_s           req,
  output logic [trap_pkg::DATA_W-1:0]       rdata_q,
  output logic [2:0]                        cpu_priority_level,
  output logic                              nesting_disable_bit,
  output logic                              irq
);
  // Bus decode
  logic        wr_ctrl;
  logic        wr_prio;
  logic        wr_en_irq;
  logic        wr_clr_irq;
  logic        div0_set;

  // Flag bits and register state
  logic        nesting_disable_q;
  logic        nesting_disable_d;
  logic        divide_zero_cause_flag;
  logic        arithmetic_trap_flag;
  logic        address_trap_flag;
  logic        stack_trap_flag;
  logic        clock_failure_trap_flag;

  logic [2:0]  prio_q;
  logic [2:0]  prio_d;
  logic [3:0]  ev_status_q;
  logic [3:0]  ev_status_d;
  logic [3:0]  ev_enable_q;
  logic [3:0]  ev_enable_d;
  logic [3:0]  ev_pulse;

  logic [15:0] ctrl_view;
  logic [15:0] rdata_d;

  // Write strobe aimed at one register index
  function automatic logic hit(
    input trap_pkg::reg_req_s r,
    input logic [3:0]         ofs
  );
    hit = r.wr && (r.addr == ofs);
  endfunction

  // Write decode per register index
  assign wr_ctrl    = hit(req, trap_pkg::OFS_TRAP_CTRL);
  assign wr_prio    = hit(req, trap_pkg::OFS_PRIO);
  assign wr_en_irq  = hit(req, trap_pkg::OFS_IRQ_ENABLE);
  assign wr_clr_irq = hit(req, trap_pkg::OFS_IRQ_CLEAR);
  // Cause flag only counts together with a math trap
  assign div0_set   = trap_ev.math & trap_ev.div_zero; // RL5

  // Trap flags; a trap beats a software write in the same cycle
  // Bit 6: math trap caused by a divide by zero
  trap_flag_bit u_div0 (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trap_set (div0_set), // RL5
    .wr_en    (wr_ctrl), // RL6
    .wr_val   (req.wdata[trap_pkg::BIT_DIV0]),
    .flag_q   (divide_zero_cause_flag)
  );

  // Bit 4: any math error trap
  trap_flag_bit u_math (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trap_set (trap_ev.math), // RL4
    .wr_en    (wr_ctrl),
    .wr_val   (req.wdata[trap_pkg::BIT_MATH]),
    .flag_q   (arithmetic_trap_flag)
  );

  // Bit 3: address error trap
  trap_flag_bit u_addr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trap_set (trap_ev.addr), // RL1
    .wr_en    (wr_ctrl),
    .wr_val   (req.wdata[trap_pkg::BIT_ADDR]),
    .flag_q   (address_trap_flag)
  );

  // Bit 2: stack error trap
  trap_flag_bit u_stack (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trap_set (trap_ev.stack), // RL2
    .wr_en    (wr_ctrl),
    .wr_val   (req.wdata[trap_pkg::BIT_STACK]),
    .flag_q   (stack_trap_flag)
  );

  // Bit 1: oscillator failure trap
  trap_flag_bit u_clkfail (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trap_set (trap_ev.clk_fail), // RL3
    .wr_en    (wr_ctrl),
    .wr_val   (req.wdata[trap_pkg::BIT_CLKFAIL]),
    .flag_q   (clock_failure_trap_flag)
  );

  // One irq status bit per trap source; the divide cause has none
  always_comb begin
    ev_pulse                      = '0;
    ev_pulse[trap_pkg::EV_MATH]    = trap_ev.math;
    ev_pulse[trap_pkg::EV_ADDR]    = trap_ev.addr;
    ev_pulse[trap_pkg::EV_STACK]   = trap_ev.stack;
    ev_pulse[trap_pkg::EV_CLKFAIL] = trap_ev.clk_fail;
  end

  // Nesting-disable bit and CPU priority level
  always_comb begin
    nesting_disable_d = nesting_disable_q;
    prio_d            = prio_q;
    if (wr_ctrl) begin
      nesting_disable_d = req.wdata[trap_pkg::BIT_NEST_DIS]; // RL8
    end
    // Priority is frozen while nesting is disabled
    if (wr_prio && !nesting_disable_q) begin
      prio_d = req.wdata[2:0]; // RL7
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nesting_disable_q <= trap_pkg::TRAP_CTRL_RESET[trap_pkg::BIT_NEST_DIS]; // RL6
      prio_q            <= trap_pkg::PRIO_RESET;
    end else begin
      nesting_disable_q <= nesting_disable_d;
      prio_q            <= prio_d;
    end
  end

  // Irq enable and sticky irq status
  always_comb begin
    ev_enable_d = ev_enable_q;
    ev_status_d = ev_status_q;
    if (wr_en_irq) begin
      ev_enable_d = req.wdata[trap_pkg::EV_W-1:0];
    end
    if (wr_clr_irq) begin
      ev_status_d = ev_status_d & ~req.wdata[trap_pkg::EV_W-1:0];
    end
    // Clear first, so a trap in the same cycle wins
    ev_status_d = ev_status_d | ev_pulse;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ev_enable_q <= trap_pkg::EV_RESET;
      ev_status_q <= trap_pkg::EV_RESET;
    end else begin
      ev_enable_q <= ev_enable_d;
      ev_status_q <= ev_status_d;
    end
  end

  // Control view; unimplemented positions stay low
  always_comb begin
    ctrl_view                        = '0; // RL6
    ctrl_view[trap_pkg::BIT_NEST_DIS] = nesting_disable_q;
    ctrl_view[trap_pkg::BIT_DIV0]     = divide_zero_cause_flag;
    ctrl_view[trap_pkg::BIT_MATH]     = arithmetic_trap_flag;
    ctrl_view[trap_pkg::BIT_ADDR]     = address_trap_flag;
    ctrl_view[trap_pkg::BIT_STACK]    = stack_trap_flag;
    ctrl_view[trap_pkg::BIT_CLKFAIL]  = clock_failure_trap_flag;
  end

  // Unmapped and write-only indices read as zero
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      case (req.addr)
        trap_pkg::OFS_TRAP_CTRL: begin
          rdata_d = ctrl_view & trap_pkg::TRAP_CTRL_MASK; // RL6
        end
        trap_pkg::OFS_PRIO: begin
          rdata_d = {13'h0000, prio_q};
        end
        trap_pkg::OFS_IRQ_STATUS: begin
          rdata_d = {12'h000, ev_status_q};
        end
        trap_pkg::OFS_IRQ_ENABLE: begin
          rdata_d = {12'h000, ev_enable_q};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= trap_pkg::TRAP_CTRL_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from registers; irq is a level
  assign cpu_priority_level  = prio_q;
  assign nesting_disable_bit = nesting_disable_q;
  assign irq                 = |(ev_status_q & ev_enable_q);
endmodule
`default_nettype wire

// ### include/trap_pkg.sv
`default_nettype none
package trap_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  // Register offsets (plain port, word index)
  localparam logic [3:0]  OFS_TRAP_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_PRIO        = 4'h1;
  localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h2;
  localparam logic [3:0]  OFS_IRQ_ENABLE  = 4'h3;
  localparam logic [3:0]  OFS_IRQ_CLEAR   = 4'h4;
  // Field positions in trap_status_and_nesting_control
  localparam int          BIT_NEST_DIS    = 15;
  localparam int          BIT_DIV0        = 6;
  localparam int          BIT_MATH        = 4;
  localparam int          BIT_ADDR        = 3;
  localparam int          BIT_STACK       = 2;
  localparam int          BIT_CLKFAIL     = 1;
  localparam logic [15:0] TRAP_CTRL_MASK  = 16'h805E;
  localparam logic [15:0] TRAP_CTRL_RESET = 16'h0000;
  localparam logic [2:0]  PRIO_RESET      = 3'h0;
  // Interrupt status bit positions
  localparam int          EV_W            = 4;
  localparam int          EV_MATH         = 0;
  localparam int          EV_ADDR         = 1;
  localparam int          EV_STACK        = 2;
  localparam int          EV_CLKFAIL      = 3;
  localparam logic [3:0]  EV_RESET        = 4'h0;

  typedef struct packed {
    logic math;
    logic div_zero;
    logic addr;
    logic stack;
    logic clk_fail;
  } trap_event_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;
endpackage
`default_nettype wire

// ### tb/trap_status_flags_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module trap_flags_chk (
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire trap_pkg::trap_event_s trap_ev,
  input wire trap_pkg::reg_req_s    req,
  input wire logic [15:0]           rdata_q,
  input wire logic [2:0]            cpu_priority_level,
  input wire logic                  nesting_disable_bit,
  input wire logic                  irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic rd0 = req.rd && req.addr == 4'h0;
  wire logic [15:0] trap_bits = {9'h000, trap_ev.math & trap_ev.div_zero, 1'b0, trap_ev.math,
    trap_ev.addr, trap_ev.stack, trap_ev.clk_fail, 1'b0};
  logic [15:0] ctrl_m;
  // Reference flags: software writes them, traps set them and win
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_m <= 16'h0000;
    end else if (req.wr && req.addr == 4'h0) begin
      ctrl_m <= (req.wdata & 16'h805E) | trap_bits;
    end else begin
      ctrl_m <= ctrl_m | trap_bits;
    end
  end
  AST_ADDR: assert property (rd0 |=> rdata_q[3] == $past(ctrl_m[3]))
    else $error("address flag wrong");
  AST_STK: assert property (rd0 |=> rdata_q[2] == $past(ctrl_m[2]))
    else $error("stack flag wrong");
  AST_CLK: assert property (rd0 |=> rdata_q[1] == $past(ctrl_m[1]))
    else $error("clock fail flag wrong");
  AST_MATH: assert property (rd0 |=> rdata_q[4] == $past(ctrl_m[4]))
    else $error("math flag wrong");
  AST_DIV: assert property (rd0 |=> rdata_q[6] == $past(ctrl_m[6]))
    else $error("divide cause wrong");
  AST_UNUSED: assert property (rd0 |=> (rdata_q & 16'h7FA1) == 16'h0000)
    else $error("unused bits not zero");
  AST_NEST: assert property (req.wr && req.addr == 4'h0 |=> nesting_disable_bit == $past(req.wdata[15]))
    else $error("nesting bit wrong");
  AST_PRIO: assert property (nesting_disable_bit && req.wr && req.addr == 4'h1 |=> $stable(cpu_priority_level))
    else $error("priority changed");
endmodule
bind trap_status_flags trap_flags_chk u_chk (.core_clk(core_clk), .rstn(rstn),
  .trap_ev(trap_ev), .req(req), .rdata_q(rdata_q), .cpu_priority_level(cpu_priority_level),
  .nesting_disable_bit(nesting_disable_bit), .irq(irq));
`default_nettype wire

// ### tb/trap_status_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("CHECK FAILED %s exp %h seen %h", n, b, a); \
  end \
end
module trap_status_flags_tb;
  logic core_clk, rstn, irq, nest, rv;
  trap_pkg::trap_event_s trap_ev;
  trap_pkg::reg_req_s    req;
  logic [15:0] rdata, e, p, q[$];
  logic [2:0]  prio;
  int fails, checked;
  logic [4:0] evs[4] = '{5'h04, 5'h02, 5'h01, 5'h10};
  int cb[4] = '{3, 2, 1, 4};
  int sb[4] = '{1, 2, 3, 0};
  trap_status_flags dut (.core_clk(core_clk), .rstn(rstn), .trap_ev(trap_ev), .req(req),
    .rdata_q(rdata), .cpu_priority_level(prio), .nesting_disable_bit(nest), .irq(irq));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge core_clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    q.push_back(x);
    @(posedge core_clk) req.rd <= 1'b0;
  endtask
  task automatic ev(input logic [4:0] x);
    @(posedge core_clk) trap_ev <= x;
    @(posedge core_clk) trap_ev <= '0;
  endtask
  task automatic ck_irq(input logic x);
    @(negedge core_clk) `CHK("irq", irq, x)
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read data judged the cycle after each read strobe
  always @(posedge core_clk) rv <= req.rd;
  always @(negedge core_clk) if (rv) begin
    e = q.pop_front();
    `CHK("rdata", rdata, e)
  end
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #200000 fails++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    trap_ev = '0;
    req = '0;
    p = 16'($urandom(32'h477C55D3));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(4'(i), 16'h0000);
    ck_irq(1'b0);
    $display("reset test done");
    wr(4'h3, 16'h000F);
    for (int k = 0; k < 4; k++) begin
      ev(evs[k]);
      rd(4'h0, 16'h0001 << cb[k]);
      rd(4'h2, 16'h0001 << sb[k]);
      ck_irq(1'b1);
      wr(4'h3, 16'h0000);
      ck_irq(1'b0);
      wr(4'h3, 16'h000F);
      wr(4'h4, 16'h0001 << sb[k]);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
      ck_irq(1'b0);
    end
    ev(5'h18);
    rd(4'h0, 16'h0050);
    wr(4'h0, 16'h0000);
    ev(5'h10);
    rd(4'h0, 16'h0010);
    wr(4'h4, 16'h000F);
    $display("trap test done");
    p = 16'($urandom);
    wr(4'h1, p);
    rd(4'h1, {13'h0000, p[2:0]});
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'h805E);
    @(negedge core_clk) `CHK("nest", nest, 1'b1)
    wr(4'h1, ~p);
    rd(4'h1, {13'h0000, p[2:0]});
    @(negedge core_clk) `CHK("prio", prio, p[2:0])
    wr(4'h0, p & 16'h7FFF);
    rd(4'h0, p & 16'h005E);
    @(negedge core_clk) `CHK("nest", nest, 1'b0)
    wr(4'h1, ~p);
    rd(4'h1, {13'h0000, ~p[2:0]});
    @(negedge core_clk) `CHK("prio", prio, ~p[2:0])
    $display("nesting test done");
    repeat (3) @(posedge core_clk);
    stop_test();
  end
endmodule
`default_nettype wire
